// ### hw/sar_adc_ctl.v
// Control and handshake logic of a successive-approximation converter.
//
// The Wishbone slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "sar_ctl_defines.vh"

// What this block does
// [RL1] Power-up calibration lasts 3840 converter clocks
// [RL2] Calibration status visible while calibrating
// [RL3] Post-calibration trims offset or one bit
// [RL4] Controller waits for calibration before starting
// [RL5] One-cycle start converts selected channel
// [RL6] Start raises sampling and busy together
// [RL7] Sampling drops after hold, busy stays
// [RL8] Completion drops busy, raises ready, result
// [RL9] Ready holds until next start
// [RL10] Start clears ready on clock edge
// [RL11] Result changes only when ready rises
// [RL12] Controller reads result while ready high
// [RL13] Five-bit binary selects one of 32
// [RL14] Channel 31 diode, channel 0 supply
// [RL15] Channels 1..30 grouped three per quad
// [RL16] Controller strobes internal temperature input
// [RL17] Powerdown gates only the comparators
// [RL18] Mode bits: calibration, powerdown, resolution
// [RL19] Short resolutions left-aligned, low bits zero
// [RL20] Converter clock is 4*(1+divider) system clocks
// [RL21] Controls sampled on rising system clock
// [RL22] Starts during busy or calibration ignored
module sar_adc_ctl (
	// Clock and reset.
	input wire clk_i,
	input wire rst_i,
	// Wishbone slave.
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [3:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output wire [31:0] dat_o,
	output wire ack_o,
	// Analog side.
	input wire comp_i,
	output wire [11:0] dac_code_o,
	output wire [4:0] channel_select_o,
	output wire [2:0] mux_src_o,
	output wire [3:0] mux_quad_o,
	output wire internal_temp_strobe_o,
	output wire comparator_powerdown_o,
	output wire [3:0] trim_sel_o,
	// Status pins.
	output wire calibrating_o,
	output wire sampling_o,
	output wire busy_o,
	output wire result_ready_flag_o,
	output wire post_cal_o,
	output wire [11:0] result_o
);

	// ----------------------------------------------------------------
	// States
	// ----------------------------------------------------------------
	localparam S_CAL = 3'h0;
	localparam S_IDLE = 3'h1;
	localparam S_SAMPLE = 3'h2;
	localparam S_CONV = 3'h3;
	localparam S_FIN = 3'h4;
	localparam S_POST = 3'h5;

	reg [31:0] cfg_r;
	reg ack_r;
	reg [31:0] dat_r;
	reg start_r;
	reg [2:0] state_r;
	reg [2:0] state_nxt;
	reg [11:0] cnt_r;
	reg [11:0] cnt_nxt;
	reg [11:0] sar_r;
	reg [11:0] sar_nxt;
	reg [3:0] bit_r;
	reg [3:0] bit_nxt;
	reg [3:0] lsb_r;
	reg [3:0] lsb_nxt;
	reg [4:0] chan_r;
	reg [3:0] trim_r;
	reg [11:0] result_r;
	reg ready_r;
	reg pd_after_r;
	reg cal_r;
	reg sampling_r;
	reg busy_r;
	reg post_r;
	reg pd_r;
	reg [31:0] status;
	wire crst;
	wire tick;
	wire bus_req;
	wire accept;
	wire done;
	wire [3:0] mode;
	wire [31:0] wmask;

	// ----------------------------------------------------------------
	// Wishbone slave
	// ----------------------------------------------------------------

	// Ack rises one clock after the request; writes land at the ack edge.
	assign bus_req = cyc_i & stb_i;
	assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
	assign ack_o = ack_r;
	assign dat_o = dat_r;
	assign mode = cfg_r[`CFG_MODE];

	// Status word assembled from flop outputs.
	always @* begin
		status = 32'h0000_0000;
		status[`ST_CAL] = cal_r; // [RL2]
		status[`ST_SAMPLE] = sampling_r;
		status[`ST_BUSY] = busy_r;
		status[`ST_READY] = ready_r;
		status[`ST_POST] = post_r;
		status[`ST_TRIM] = trim_r;
	end

	// Bus response; the control word reads zero, status and result ignore writes.
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0000_0000;
			cfg_r <= `CFG_RESET;
			start_r <= 1'b0;
		end else begin
			ack_r <= bus_req & ~ack_r;
			start_r <= 1'b0;
			if (bus_req & ~ack_r) begin
				case (adr_i[3:2])
					`REG_CONFIG: dat_r <= cfg_r;
					`REG_STATUS: dat_r <= status;
					`REG_RESULT: dat_r <= {20'h0_0000, result_r};
					default: dat_r <= 32'h0000_0000;
				endcase
			end
			if (bus_req & ack_r & we_i) begin
				case (adr_i[3:2])
					`REG_CONFIG: begin
						cfg_r <= ((cfg_r & ~wmask) | (dat_i & wmask)) & `CFG_MASK; // [RL18]
					end
					`REG_CONTROL: begin
						// A single write gives a one-clock start. [RL5] [RL21]
						start_r <= sel_i[0] & dat_i[`CTL_START];
					end
					default: begin
						start_r <= 1'b0;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Converter clock and channel routing
	// ----------------------------------------------------------------

	// Software converter reset restarts calibration without losing config.
	assign crst = rst_i | cfg_r[`CFG_CRST];

	conv_tick_gen u_tick (
		.clk_i(clk_i),
		.rst_i(crst),
		.div_i(cfg_r[`CFG_DIV]),
		.tick_o(tick)
	);

	channel_route u_route (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.chan_i(chan_r), // [RL13]
		.src_o(mux_src_o),
		.quad_o(mux_quad_o)
	);

	// ----------------------------------------------------------------
	// Conversion sequencer
	// ----------------------------------------------------------------

	// Starts outside idle are dropped; the running sequence is untouched.
	// A converter reset also refuses starts, so ready never drops without a sampling phase.
	assign accept = start_r & (state_r == S_IDLE) & ~crst; // [RL22]
	assign done = (state_r == S_FIN) & tick;

	// Next-state logic; every state but idle advances on converter ticks, idle leaves on an accepted start.
	always @* begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		sar_nxt = sar_r;
		bit_nxt = bit_r;
		lsb_nxt = lsb_r;
		case (state_r)
			S_CAL: begin
				if (tick) begin
					cnt_nxt = cnt_r + 12'h001;
					if (cnt_r == `CAL_TICKS - 12'h001) begin
						state_nxt = S_IDLE; // [RL1]
						cnt_nxt = 12'h000;
					end
				end
			end
			S_IDLE: begin
				if (accept) begin
					state_nxt = S_SAMPLE; // [RL6]
					cnt_nxt = 12'h000;
					sar_nxt = 12'h000;
					case (mode[`MODE_RES])
						`RES_10: lsb_nxt = `LSB_10; // [RL19]
						`RES_8: lsb_nxt = `LSB_8; // [RL19]
						default: lsb_nxt = `LSB_12;
					endcase
				end
			end
			S_SAMPLE: begin
				if (tick) begin
					cnt_nxt = cnt_r + 12'h001;
					if (cnt_r[1:0] == `SAMPLE_TICKS - 2'h1) begin
						state_nxt = S_CONV; // [RL7]
						sar_nxt = `SAR_FIRST;
						bit_nxt = `SAR_MSB;
						cnt_nxt = 12'h000;
					end
				end
			end
			S_CONV: begin
				if (tick) begin
					// Keep the trial bit only when the comparator says so.
					if (!comp_i) begin
						sar_nxt[bit_r] = 1'b0;
					end
					if (bit_r == lsb_r) begin
						state_nxt = S_FIN;
					end else begin
						bit_nxt = bit_r - 4'h1;
						sar_nxt[bit_r - 4'h1] = 1'b1;
					end
				end
			end
			S_FIN: begin
				if (tick) begin
					state_nxt = mode[`MODE_NOCAL] ? S_IDLE : S_POST; // [RL18]
					cnt_nxt = 12'h000;
				end
			end
			S_POST: begin
				if (tick) begin
					cnt_nxt = cnt_r + 12'h001;
					if (cnt_r[1:0] == `POST_TICKS - 2'h1) begin
						state_nxt = S_IDLE; // [RL3]
						cnt_nxt = 12'h000;
					end
				end
			end
			default: begin
				state_nxt = S_CAL;
				cnt_nxt = 12'h000;
			end
		endcase
	end

	// Sequencer registers and status flags, all taken from the next state.
	always @(posedge clk_i) begin
		if (crst) begin
			state_r <= S_CAL;
			cnt_r <= 12'h000;
			sar_r <= 12'h000;
			bit_r <= `SAR_MSB;
			lsb_r <= `LSB_12;
			cal_r <= 1'b1;
			sampling_r <= 1'b0;
			busy_r <= 1'b0;
			post_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			sar_r <= sar_nxt;
			bit_r <= bit_nxt;
			lsb_r <= lsb_nxt;
			cal_r <= (state_nxt == S_CAL); // [RL2]
			sampling_r <= (state_nxt == S_SAMPLE); // [RL6] [RL7]
			busy_r <= (state_nxt == S_SAMPLE) | (state_nxt == S_CONV) |
				(state_nxt == S_FIN); // [RL6] [RL8]
			post_r <= (state_nxt == S_POST);
		end
	end

	// ----------------------------------------------------------------
	// Result, ready flag and trim pointer
	// ----------------------------------------------------------------

	// The result register loads only on the edge where ready rises.
	// A converter reset keeps both, so a recalibration never loses a finished value.
	always @(posedge clk_i) begin
		if (rst_i) begin
			ready_r <= 1'b0;
			result_r <= 12'h000;
		end else if (accept) begin
			ready_r <= 1'b0; // [RL9] [RL10]
		end else if (done) begin
			ready_r <= 1'b1; // [RL8]
			result_r <= sar_r; // [RL11] [RL19]
		end
	end

	// Latched channel and the powerdown request follow the converter reset.
	always @(posedge clk_i) begin
		if (crst) begin
			chan_r <= 5'h00;
			pd_after_r <= 1'b0;
		end else if (accept) begin
			chan_r <= cfg_r[`CFG_CHAN]; // [RL5]
			pd_after_r <= 1'b0;
		end else if (done) begin
			pd_after_r <= ~mode[`MODE_NOPD]; // [RL18]
		end
	end

	// Each post-calibration steps through the offset, then bits 0..11.
	always @(posedge clk_i) begin
		if (crst) begin
			trim_r <= 4'h0;
		end else if ((state_r == S_POST) && (state_nxt == S_IDLE)) begin
			trim_r <= (trim_r == `TRIM_LAST) ? 4'h0 : trim_r + 4'h1; // [RL3]
		end
	end

	// Powerdown touches only the comparators; digital logic keeps running.
	always @(posedge clk_i) begin
		if (rst_i) begin
			pd_r <= 1'b0;
		end else begin
			pd_r <= cfg_r[`CFG_PWRDN] | pd_after_r; // [RL17]
		end
	end

	// ----------------------------------------------------------------
	// Output assignments, all from flops
	// ----------------------------------------------------------------
	assign dac_code_o = sar_r;
	assign channel_select_o = chan_r;
	assign internal_temp_strobe_o = cfg_r[`CFG_TSTRB];
	assign comparator_powerdown_o = pd_r;
	assign trim_sel_o = trim_r;
	assign calibrating_o = cal_r;
	assign sampling_o = sampling_r;
	assign busy_o = busy_r;
	assign result_ready_flag_o = ready_r;
	assign post_cal_o = post_r;
	assign result_o = result_r;

endmodule

// ### hw/sar_ctl_defines.vh
// Constants shared by the converter control block and its helpers.
`ifndef SAR_CTL_DEFINES_VH
`define SAR_CTL_DEFINES_VH

// ----------------------------------------------------------------
// Register word indices (Wishbone address bits 3:2)
// ----------------------------------------------------------------
`define REG_CONFIG 2'h0
`define REG_CONTROL 2'h1
`define REG_STATUS 2'h2
`define REG_RESULT 2'h3

// ----------------------------------------------------------------
// Configuration register fields and reset value
// ----------------------------------------------------------------
`define CFG_RESET 32'h0000_000d
`define CFG_MODE 3:0
`define CFG_DIV 15:8
`define CFG_CHAN 20:16
`define CFG_PWRDN 24
`define CFG_TSTRB 25
`define CFG_CRST 26
`define CFG_MASK 32'h071f_ff0f
`define CTL_START 0

// ----------------------------------------------------------------
// Mode field
// ----------------------------------------------------------------
`define MODE_NOCAL 3
`define MODE_NOPD 2
`define MODE_RES 1:0
`define RES_10 2'h0
`define RES_12 2'h1
`define RES_8 2'h2

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define ST_CAL 0
`define ST_SAMPLE 1
`define ST_BUSY 2
`define ST_READY 3
`define ST_POST 4
`define ST_TRIM 11:8

// ----------------------------------------------------------------
// Timing in converter clock periods, trim range and SAR bit positions
// ----------------------------------------------------------------
`define CAL_TICKS 12'h0f00
`define POST_TICKS 2'h2
`define SAMPLE_TICKS 2'h2
`define TRIM_LAST 4'hc
`define SAR_MSB 4'hb
`define SAR_FIRST 12'h0800
`define LSB_12 4'h0
`define LSB_10 4'h2
`define LSB_8 4'h4

// ----------------------------------------------------------------
// Input multiplexer channels and source kinds
// ----------------------------------------------------------------
`define CH_SUPPLY 5'h00
`define CH_DIODE 5'h1f
`define SRC_SUPPLY 3'h0
`define SRC_VOLT 3'h1
`define SRC_CURR 3'h2
`define SRC_QTEMP 3'h3
`define SRC_DIODE 3'h4

`endif

// ### hw/conv_tick_gen.v
// Converter clock generator: one tick per converter clock period.
`timescale 1ns/1ps
`include "sar_ctl_defines.vh"

module conv_tick_gen (
	// Clock and restart.
	input wire clk_i,
	input wire rst_i,
	// Divider setting.
	input wire [7:0] div_i,
	// Tick, one system clock wide.
	output wire tick_o
);

	reg [9:0] cnt_r;
	reg tick_r;
	wire [9:0] last;

	// Period is four times one plus the divider, in system clocks.
	assign last = {div_i, 2'h3}; // [RL20]
	assign tick_o = tick_r;

	// Free count; a divider change takes effect at the next wrap or compare.
	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt_r <= 10'h000;
			tick_r <= 1'b0;
		end else if (cnt_r >= last) begin
			cnt_r <= 10'h000;
			tick_r <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 10'h001;
			tick_r <= 1'b0;
		end
	end

endmodule

// ### hw/channel_route.v
// Decodes a channel number into the multiplexer source and quad.
`timescale 1ns/1ps
`include "sar_ctl_defines.vh"

module channel_route (
	// Clock and reset.
	input wire clk_i,
	input wire rst_i,
	// Channel number.
	input wire [4:0] chan_i,
	// Registered route.
	output reg [2:0] src_o,
	output reg [3:0] quad_o
);

	wire [4:0] idx;
	wire [4:0] quad;
	wire [4:0] rem;

	// Channels 1..30 fall in groups of three per quad.
	assign idx = chan_i - 5'h01;
	assign quad = idx / 5'h03;
	assign rem = idx - quad * 5'h03;

	// Fixed channels win over the quad arithmetic.
	always @(posedge clk_i) begin
		if (rst_i) begin
			src_o <= `SRC_SUPPLY;
			quad_o <= 4'h0;
		end else if (chan_i == `CH_SUPPLY) begin
			src_o <= `SRC_SUPPLY; // [RL14]
			quad_o <= 4'h0;
		end else if (chan_i == `CH_DIODE) begin
			src_o <= `SRC_DIODE; // [RL14]
			quad_o <= 4'h0;
		end else begin
			src_o <= (rem == 5'h00) ? `SRC_VOLT :
				(rem == 5'h01) ? `SRC_CURR : `SRC_QTEMP; // [RL15]
			quad_o <= quad[3:0]; // [RL15]
		end
	end

endmodule

// ### tb/analog_model.sv
// Comparator model standing in for the multiplexed analog input.
`timescale 1ns/1ps
// ----------------------------------------
// Analog side
// ----------------------------------------
module analog_model (
	// Trial word and level of the selected input.
	input wire [11:0] dac_code_i,
	input wire [11:0] level_i,
	// Comparator decision.
	output wire comp_o
);
	// Keep the trial bit while the input is at or above the trial word.
	assign comp_o = (level_i >= dac_code_i);
endmodule

// ### tb/sar_adc_ctl_props.sv
// Concurrent checks on the converter control ports.
`timescale 1ns/1ps
`include "sar_ctl_defines.vh"
// ----------------------------------------
// Checker
// ----------------------------------------
module sar_adc_ctl_chk (
	// Clock, reset and bus.
	input wire clk_i,
	input wire rst_i,
	input wire cyc_i,
	input wire stb_i,
	input wire ack_o,
	// Status.
	input wire calibrating_o,
	input wire sampling_o,
	input wire busy_o,
	input wire result_ready_flag_o,
	input wire [11:0] result_o,
	// Route.
	input wire [4:0] channel_select_o,
	input wire [2:0] mux_src_o,
	input wire [3:0] mux_quad_o
);
	reg [15:0] cal_n_r;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Ticks restart with the converter reset, which may be held a few clocks, so the length is allowed a few clocks of slack.
	// The count restarts whenever calibration is not running, so a converter reset is measured too.
	always @(posedge clk_i) begin
		if (rst_i || !calibrating_o) cal_n_r <= 16'h0000;
		else cal_n_r <= cal_n_r + 16'h0001;
	end
	// Source and quad expected for a channel number.
	function automatic [6:0] route(input [4:0] c);
		if (c == `CH_SUPPLY) route = {`SRC_SUPPLY, 4'h0};
		else if (c == `CH_DIODE) route = {`SRC_DIODE, 4'h0};
		else route = {3'((c - 5'h01) % 5'h03 + 5'h01), 4'((c - 5'h01) / 5'h03)};
	endfunction
	sequence accept_s; $rose(sampling_o) && $rose(busy_o); endsequence
	sequence finish_s; !busy_o && result_ready_flag_o; endsequence
	ack_next_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
	ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
	cal_len_a: assert property ($fell(calibrating_o) |-> cal_n_r >= 16'h3bf8 && cal_n_r <= 16'h3c08)
		else $error("calibration length wrong");
	cal_quiet_a: assert property (calibrating_o |-> !busy_o && !sampling_o) else $error("start in cal");
	samp_busy_a: assert property ($rose(sampling_o) |-> accept_s) else $error("sample without busy");
	samp_drop_a: assert property ($fell(sampling_o) |-> busy_o) else $error("busy left early");
	conv_done_a: assert property ($fell(busy_o) |-> finish_s) else $error("no ready at end");
	ready_clear_a: assert property ($fell(result_ready_flag_o) |-> accept_s) else $error("ready lost");
	result_hold_a: assert property (!$rose(result_ready_flag_o) |-> $stable(result_o))
		else $error("result moved");
	route_map_a: assert property (1'b1 |=> {mux_src_o, mux_quad_o} == route($past(channel_select_o)))
		else $error("route wrong");
endmodule
bind sar_adc_ctl sar_adc_ctl_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
	.ack_o(ack_o), .calibrating_o(calibrating_o), .sampling_o(sampling_o), .busy_o(busy_o),
	.result_ready_flag_o(result_ready_flag_o), .result_o(result_o),
	.channel_select_o(channel_select_o), .mux_src_o(mux_src_o), .mux_quad_o(mux_quad_o));

// ### tb/sar_adc_conversion_control_bench.sv
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
`include "sar_ctl_defines.vh"
// ----------------------------------------
// Bench
// ----------------------------------------
module sar_adc_conversion_control_bench;
	reg clk_i = 1'b0;
	reg rst_i = 1'b1;
	reg cyc_i = 1'b0;
	reg stb_i = 1'b0;
	reg we_i = 1'b0;
	reg [3:0] adr_i = 4'h0;
	reg [31:0] dat_i = 32'h0000_0000;
	reg [11:0] level = 12'h000;
	wire [31:0] dat_o;
	wire [11:0] dac, result_o;
	wire [4:0] chan;
	wire [2:0] src;
	wire [3:0] quad, trim;
	wire ack_o, comp, cal, samp, busy, rdy, post, pd, ts;
	int n_mismatch = 0;
	int total_checks = 0;
	int n_post = 0;
	int i, k;
	reg [31:0] seed = 32'h0000_5a1e;
	reg [31:0] rd, cfg;
	reg [4:0] ch;
	reg [11:0] exp_res;
	reg pc;
	reg [3:0] modes [4] = '{4'hd, 4'h4, 4'h2, 4'h7};
	sar_adc_ctl u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .comp_i(comp),
		.dac_code_o(dac), .channel_select_o(chan), .mux_src_o(src), .mux_quad_o(quad),
		.internal_temp_strobe_o(ts), .comparator_powerdown_o(pd), .trim_sel_o(trim),
		.calibrating_o(cal), .sampling_o(samp), .busy_o(busy), .result_ready_flag_o(rdy),
		.post_cal_o(post), .result_o(result_o));
	analog_model u_ana (.dac_code_i(dac), .level_i(level), .comp_o(comp));
	// Free-running 40 MHz clock.
	initial begin
		forever #12.5 clk_i = ~clk_i;
	end
	function automatic [31:0] xs(input [31:0] s);
		reg [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		xs = t ^ (t << 5);
	endfunction
	// Behavioural multiplexer map, worked out with integers.
	function automatic [6:0] route(input int c);
		if (c == 0 || c == 31) route = {(c == 31) ? 3'h4 : 3'h0, 4'h0};
		else route = {3'((c - 1) % 3 + 1), 4'((c - 1) / 3)};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One classic Wishbone cycle; the request is held until ack is sampled.
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		@(posedge clk_i);
		while (ack_o !== 1'b1) @(posedge clk_i);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Main sequence: reset, calibration, then one conversion per channel case.
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, {`REG_CONFIG, 2'b00}, 32'h0000_0000);
		check(rd, `CFG_RESET);
		wb(1'b0, {`REG_STATUS, 2'b00}, 32'h0000_0000);
		check(rd[`ST_CAL], 1'b1);
		wb(1'b1, {`REG_CONTROL, 2'b00}, 32'h0000_0001);
		repeat (8) @(posedge clk_i);
		check(busy, 1'b0);
		for (k = 0; k < 20000 && cal !== 1'b0; k++) @(posedge clk_i);
		check(k >= 15320 && k <= 15370, 1'b1);
		for (i = 0; i < 5; i++) begin
			seed = xs(seed);
			level <= seed[11:0];
			ch = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : (i == 2) ? 5'h01 : (i == 3) ? 5'h1e : seed[20:16] % 5'h1f;
			cfg = {6'h00, (i == 3) ? 2'h3 : 2'h0, 3'h0, ch, 7'h00, seed[8], 4'h0, modes[i % 4]};
			wb(1'b1, {`REG_CONFIG, 2'b00}, cfg);
			wb(1'b1, {`REG_CONTROL, 2'b00}, 32'h0000_0001);
			for (k = 0; k < 8 && samp !== 1'b1; k++) @(posedge clk_i);
			check({samp, busy, rdy}, 3'b110);
			// A second start while busy must leave the conversion alone.
			wb(1'b1, {`REG_CONTROL, 2'b00}, 32'h0000_0001);
			for (k = 0; k < 3000 && rdy !== 1'b1; k++) @(posedge clk_i);
			exp_res = level & ((cfg[1:0] == `RES_10) ? 12'hffc : (cfg[1:0] == `RES_8) ? 12'hff0 : 12'hfff);
			check({busy, rdy, result_o}, {2'b01, exp_res});
			check({src, quad}, route(ch));
			check(chan, ch);
			pc = 1'b0;
			repeat (40) begin
				@(posedge clk_i);
				pc = pc | post;
			end
			check(pc, !cfg[`MODE_NOCAL]);
			if (!cfg[`MODE_NOCAL]) n_post++;
			check(trim, n_post);
			check({rdy, busy}, 2'b10);
			check({pd, ts}, {(i == 3) || !cfg[`MODE_NOPD], i == 3});
			wb(1'b0, {`REG_RESULT, 2'b00}, 32'h0000_0000);
			check(rd, {20'h0_0000, exp_res});
			$display("test %0d done", i);
		end
		// Converter reset: calibration runs again while ready and the result stay.
		wb(1'b1, {`REG_CONFIG, 2'b00}, cfg | 32'h0400_0000);
		wb(1'b1, {`REG_CONFIG, 2'b00}, cfg);
		check({cal, rdy, result_o}, {2'b11, exp_res});
		wb(1'b1, {`REG_CONTROL, 2'b00}, 32'h0000_0001);
		repeat (8) @(posedge clk_i);
		check(busy, 1'b0);
		for (k = 0; k < 20000 && cal !== 1'b0; k++) @(posedge clk_i);
		check(k >= 15320 && k <= 15370, 1'b1);
		wb(1'b1, {`REG_CONTROL, 2'b00}, 32'h0000_0001);
		for (k = 0; k < 3000 && rdy !== 1'b0; k++) @(posedge clk_i);
		check({samp, busy, rdy}, 3'b110);
		for (k = 0; k < 3000 && rdy !== 1'b1; k++) @(posedge clk_i);
		check({busy, rdy, result_o}, {2'b01, exp_res});
		check(chan, ch);
		$display("test converter reset done");
		end_sim;
	end
	// Watchdog: the whole run needs about 31400 cycles, two calibrations included.
	initial begin
		#(25 * 60000);
		n_mismatch++;
		end_sim;
	end
endmodule
